/* File: design/adc_pkg.sv */
// Constants, types and register layout of the converter sequencer.
// Assumes one 25 MHz clock and a 16-bit register port with 5 address bits.
package adc_pkg;
  // ****************************************
  // Register map and bit positions
  // ****************************************
  localparam logic [4:0] REG_CTRL1 = 5'h00;
  localparam logic [4:0] REG_CTRL2 = 5'h01;
  localparam logic [4:0] REG_CTRL3 = 5'h02;
  localparam logic [4:0] REG_CHSEL = 5'h03;
  localparam int BUF_SEL_BIT = 4;
  localparam logic [15:0] CTRL1_WMASK = 16'ha7ec;
  localparam logic [15:0] CTRL2_WMASK = 16'he73f;
  localparam logic [15:0] CTRL3_WMASK = 16'h9fff;
  localparam logic [15:0] CHSEL_WMASK = 16'h0707;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam int ON_BIT = 15;
  localparam int SIDL_BIT = 13;
  localparam int RES_BIT = 10;
  localparam int FORM_LSB = 8;
  localparam int SSRC_LSB = 5;
  localparam int SIMULTANEOUS_SAMPLE_BIT = 3;
  localparam int AUTO_SAMPLE_START_BIT = 2;
  localparam int SAMPLE_ACTIVE_BIT = 1;
  localparam int DONE_BIT = 0;
  localparam int VCFG_LSB = 13;
  localparam int SCAN_ENABLE_BIT = 10;
  localparam int CHPS_LSB = 8;
  localparam int BUFFER_HALF_STATUS_BIT = 7;
  localparam int SMPI_LSB = 2;
  localparam int SPLIT_BUFFER_MODE_BIT = 1;
  localparam int ALTERNATE_SAMPLE_MODE_BIT = 0;
  localparam int RC_CLOCK_SELECT_BIT = 15;
  localparam int SAMC_LSB = 8;
  localparam int NB_LSB = 9;
  localparam int NA_LSB = 1;
  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_EXT = 3'h1;
  localparam logic [2:0] TRIG_TMR3 = 3'h2;
  localparam logic [2:0] TRIG_PWM1 = 3'h3;
  localparam logic [2:0] TRIG_PWM2 = 3'h5;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;
  localparam logic [1:0] NEG_PINS = 2'h2;
  localparam logic [7:0] DIV_LIMIT = 8'h40;
  localparam logic [5:0] DIV_MAX = 6'h3f;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {S_OFF, S_WAIT, S_SAMPLE, S_START, S_BUSY} seq_state_t;
  typedef struct packed {
    logic enable;
    logic sampling;
    logic start;
    logic [1:0] chan;
    logic simult;
    logic use_b;
    logic scan;
    logic ref_pos_ext;
    logic ref_neg_ext;
    logic neg_pins;
    logic rc_clk;
  } analog_ctrl_t;
  typedef struct packed {
    logic done;
    logic [11:0] data;
  } conv_result_t;
endpackage

/* File: design/result_format.sv */
// Packs a raw converter code into the selected 16-bit result format.
// Assumes the raw code is right-aligned; 10-bit mode uses the low ten bits.
`timescale 1ns/1ps
module result_format import adc_pkg::*; (
  input wire logic [11:0] raw,
  input wire logic res12,
  input wire logic [1:0] fmt,
  output logic [15:0] packed_out
);
  // ****************************************
  // Format selection
  // ****************************************
  // Signed forms use the inverted top data bit as sign.
  wire logic s10 = ~raw[9];
  wire logic s12 = ~raw[11];
  wire logic [15:0] f10_int = {6'h00, raw[9:0]};
  wire logic [15:0] f10_sint = {{7{s10}}, raw[8:0]};
  wire logic [15:0] f10_frac = {raw[9:0], 6'h00};
  wire logic [15:0] f10_sfrac = {s10, raw[8:0], 6'h00};
  wire logic [15:0] f12_int = {4'h0, raw};
  wire logic [15:0] f12_sint = {{5{s12}}, raw[10:0]};
  wire logic [15:0] f12_frac = {raw, 4'h0};
  wire logic [15:0] f12_sfrac = {s12, raw[10:0], 4'h0};
  // The four codes mean the same in both resolutions.
  assign packed_out = (fmt == FMT_SFRAC) ? (res12 ? f12_sfrac : f10_sfrac) :
                      (fmt == FMT_FRAC) ? (res12 ? f12_frac : f10_frac) :
                      (fmt == FMT_SINT) ? (res12 ? f12_sint : f10_sint) :
                      (res12 ? f12_int : f10_int);
endmodule

/* File: design/result_buffer.sv */
// Sixteen-word result memory with one write port and a registered read.
// Assumes reads and writes come from the same clock domain.
`timescale 1ns/1ps
module result_buffer (
  input wire logic clk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [16];
  // ****************************************
  // Storage
  // ****************************************
  // Read data always come from a register, a cycle after the address.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* File: design/adc_sequencer_control.sv */
// Sequencer for a successive-approximation converter: registers, sampling,
// trigger choice, conversion clock, result buffer and interrupt pacing.
// Assumes trigger pulses and converter results on clk; pins are synchronised.
// How it works
// - Converter runs only while converter_on is set.
// - With stop_in_idle set, operation pauses while idle_mode is high.
// - resolution_select picks 12-bit single channel or 10-bit up to four.
// - 10-bit results packed per output_format: integer, signed, fractional.
// - 12-bit results use same codes; fractional leaves four zero bits.
// - trigger_source picks counter, PWM, timer, pin edge or software end.
// - simultaneous_sample samples channels together; reads zero in 12-bit.
// - auto_sample_start restarts sampling after each sequence.
// - Software clear ends sampling for code 000, hardware otherwise.
// - Done set on completion; software may only clear it.
// - Done cleared at conversion start; software clear disturbs nothing.
// - reference_config chooses external or supply references.
// - scan_enable scans channel 0 positive input during sample A.
// - channel_count converts one, two or four channels; zero in 12-bit.
// - buffer_half_status shows which half is being filled.
// - Interrupt after every N-th sequence, N is interval field plus one.
// - Split mode alternates buffer halves per interrupt, else restarts.
// - alternate_sample_mode alternates sample A and B selections.
// - rc_clock_select picks RC clock or divided system clock.
// - Counter trigger samples for auto_sample_time conversion periods.
// - Period is clock times divider plus one, at most 64.
// - Group negative field 10 routes to input pins in 10-bit mode, else reference.
// - Results land in a sixteen-word buffer that software reads.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module adc_sequencer_control import adc_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic idle_mode,
  input wire logic trig_timer3,
  input wire logic trig_pwm1,
  input wire logic trig_pwm2,
  input wire logic external_trigger_pin,
  input wire logic rc_osc_pin,
  input wire conv_result_t conv_result,
  output analog_ctrl_t analog_ctrl,
  output logic converter_interrupt_flag
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0] ctrl1_r, ctrl2_r, ctrl3_r, chsel_r;
  seq_state_t state_r, state_nxt;
  logic done_r, done_nxt;
  logic [1:0] ch_r;
  logic [3:0] seq_cnt_r;
  logic half_r;
  logic [3:0] wptr_r;
  logic alt_b_r;
  logic [4:0] sample_active_cnt_r;
  logic [5:0] tad_cnt_r;
  logic [2:0] ext_sync_r, rc_sync_r;
  logic [15:0] reg_q_r;
  logic rd_mem_r;
  logic [15:0] mem_q, fmt_data;

  // ****************************************
  // Field views
  // ****************************************
  // Fields that must read zero in 12-bit mode are masked here.
  wire logic conv_on = ctrl1_r[ON_BIT];
  wire logic stop_in_idle = ctrl1_r[SIDL_BIT];
  wire logic resolution_select = ctrl1_r[RES_BIT];
  wire logic [1:0] output_format = ctrl1_r[FORM_LSB+:2];
  wire logic [2:0] trigger_source = ctrl1_r[SSRC_LSB+:3];
  wire logic simultaneous_sample = ctrl1_r[SIMULTANEOUS_SAMPLE_BIT] & ~resolution_select;
  wire logic auto_sample_start = ctrl1_r[AUTO_SAMPLE_START_BIT];
  wire logic [2:0] reference_config = ctrl2_r[VCFG_LSB+:3];
  wire logic scan_enable = ctrl2_r[SCAN_ENABLE_BIT];
  wire logic [1:0] channel_count = resolution_select ? 2'h0 : ctrl2_r[CHPS_LSB+:2];
  wire logic [3:0] sequences_per_interrupt = ctrl2_r[SMPI_LSB+:4];
  wire logic split_buffer_mode = ctrl2_r[SPLIT_BUFFER_MODE_BIT];
  wire logic alternate_sample_mode = ctrl2_r[ALTERNATE_SAMPLE_MODE_BIT];
  wire logic rc_clock_select = ctrl3_r[RC_CLOCK_SELECT_BIT];
  wire logic [4:0] auto_sample_time = ctrl3_r[SAMC_LSB+:5];
  wire logic [7:0] clock_divider = ctrl3_r[7:0];
  wire logic [1:0] group_neg_input_b = chsel_r[NB_LSB+:2];
  wire logic [1:0] group_neg_input_a = chsel_r[NA_LSB+:2];
  wire logic sample_active = (state_r == S_SAMPLE);
  wire logic buffer_half_status = half_r & split_buffer_mode;

  // ****************************************
  // Decode helpers
  // ****************************************
  // Negative routing to pins only for code 10 in 10-bit mode.
  function automatic logic neg_to_pins(input logic [1:0] sel, input logic res12);
    neg_to_pins = (sel == NEG_PINS) & ~res12;
  endfunction

  // Register write decode.
  wire logic wr_c1 = wr_en & (addr == REG_CTRL1);
  wire logic wr_c2 = wr_en & (addr == REG_CTRL2);
  wire logic wr_c3 = wr_en & (addr == REG_CTRL3);
  wire logic wr_cs = wr_en & (addr == REG_CHSEL);
  wire logic sw_sample_active_set = wr_c1 & wdata[SAMPLE_ACTIVE_BIT];
  wire logic sw_sample_active_clr = wr_c1 & ~wdata[SAMPLE_ACTIVE_BIT];
  wire logic sw_done_clr = wr_c1 & ~wdata[DONE_BIT];

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops before use; the third stage only serves edge detection.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ext_sync_r <= 3'h0;
      rc_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], external_trigger_pin};
      rc_sync_r <= {rc_sync_r[1:0], rc_osc_pin};
    end
  end
  wire logic ext_edge = ext_sync_r[1] & ~ext_sync_r[2];
  wire logic rc_edge = rc_sync_r[1] & ~rc_sync_r[2];

  // ****************************************
  // Conversion clock period
  // ****************************************
  // Reserved divider codes of 64 and above clamp to the longest period.
  wire logic [5:0] div_eff = (clock_divider >= DIV_LIMIT) ? DIV_MAX : clock_divider[5:0];
  wire logic div_tick = (tad_cnt_r >= div_eff);
  wire logic tad_tick = rc_clock_select ? rc_edge : div_tick;
  always_ff @(posedge clk) begin
    if (!reset_n || rc_clock_select || div_tick) begin
      tad_cnt_r <= 6'h00;
    end else begin
      tad_cnt_r <= tad_cnt_r + 6'h01;
    end
  end

  // ****************************************
  // Sampling time and trigger choice
  // ****************************************
  // The sample counter runs in conversion periods while sampling.
  wire logic auto_end = (sample_active_cnt_r == auto_sample_time);
  always_ff @(posedge clk) begin
    if (!reset_n || !sample_active) begin
      sample_active_cnt_r <= 5'h00;
    end else if (tad_tick && !auto_end) begin
      sample_active_cnt_r <= sample_active_cnt_r + 5'h01;
    end
  end
  // Reserved trigger codes never end sampling.
  wire logic hw_trig = (trigger_source == TRIG_AUTO) ? auto_end :
                       (trigger_source == TRIG_PWM2) ? trig_pwm2 :
                       (trigger_source == TRIG_PWM1) ? trig_pwm1 :
                       (trigger_source == TRIG_TMR3) ? trig_timer3 :
                       (trigger_source == TRIG_EXT) ? ext_edge : 1'b0;
  wire logic end_sample_active = (trigger_source == TRIG_SW) ? sw_sample_active_clr : hw_trig;
  wire logic halted = stop_in_idle & idle_mode;
  wire logic last_ch = (ch_r == 2'h3) || (channel_count == 2'h0) ||
                       ((channel_count == 2'h1) && (ch_r == 2'h1));

  // ****************************************
  // Sequence state machine
  // ****************************************
  // Off forces reset of the flow; idle stop freezes it in place.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_OFF: state_nxt = S_WAIT;
      S_WAIT: if (auto_sample_start || sw_sample_active_set) begin
        state_nxt = S_SAMPLE;
      end
      S_SAMPLE: if (end_sample_active) begin
        state_nxt = S_START;
      end
      S_START: state_nxt = S_BUSY;
      S_BUSY: if (conv_result.done) begin
        if (!last_ch) begin
          state_nxt = S_START;
        end else if (auto_sample_start) begin
          state_nxt = S_SAMPLE;
        end else begin
          state_nxt = S_WAIT;
        end
      end
      default: state_nxt = S_OFF;
    endcase
    if (halted) begin
      state_nxt = state_r;
    end
    if (!conv_on) begin
      state_nxt = S_OFF;
    end
  end
  wire logic start_conv = sample_active & (state_nxt == S_START);
  wire logic buf_we = (state_r == S_BUSY) & conv_result.done & conv_on & ~halted;
  wire logic seq_done = buf_we & last_ch;
  wire logic irq = seq_done & (seq_cnt_r == sequences_per_interrupt);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_r <= S_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Done flag
  // ****************************************
  // Completion wins over a software clear; writing one is ignored.
  always_comb begin
    done_nxt = done_r;
    if (start_conv || sw_done_clr) begin
      done_nxt = 1'b0;
    end
    if (seq_done) begin
      done_nxt = 1'b1;
    end
  end

  // ****************************************
  // Sequence, buffer and alternation counters
  // ****************************************
  // The buffer pointer restarts or swaps halves on every interrupt.
  always_ff @(posedge clk) begin
    if (!reset_n || !conv_on) begin
      done_r <= reset_n & done_nxt;
      ch_r <= 2'h0;
      seq_cnt_r <= 4'h0;
      half_r <= 1'b0;
      wptr_r <= 4'h0;
      alt_b_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      if (buf_we) begin
        ch_r <= last_ch ? 2'h0 : ch_r + 2'h1;
      end
      if (irq) begin
        seq_cnt_r <= 4'h0;
        half_r <= split_buffer_mode & ~half_r;
        wptr_r <= {split_buffer_mode & ~half_r, 3'h0};
      end else if (seq_done) begin
        seq_cnt_r <= seq_cnt_r + 4'h1;
        wptr_r <= wptr_r + 4'h1;
      end else if (buf_we) begin
        wptr_r <= wptr_r + 4'h1;
      end
      if (start_conv) begin
        alt_b_r <= alternate_sample_mode & ~alt_b_r;
      end
    end
  end

  // ****************************************
  // Result path
  // ****************************************
  result_format u_fmt (
    .raw(conv_result.data),
    .res12(resolution_select),
    .fmt(output_format),
    .packed_out(fmt_data)
  );
  result_buffer u_buf (
    .clk(clk),
    .we(buf_we),
    .waddr(wptr_r),
    .wdata(fmt_data),
    .raddr(addr[3:0]),
    .rdata(mem_q)
  );

  // ****************************************
  // Control registers
  // ****************************************
  // Only writable bits are stored; sample and done live in the sequencer.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl1_r <= REG_RESET;
      ctrl2_r <= REG_RESET;
      ctrl3_r <= REG_RESET;
      chsel_r <= REG_RESET;
    end else begin
      if (wr_c1) ctrl1_r <= wdata & CTRL1_WMASK;
      if (wr_c2) ctrl2_r <= wdata & CTRL2_WMASK;
      if (wr_c3) ctrl3_r <= wdata & CTRL3_WMASK;
      if (wr_cs) chsel_r <= wdata & CHSEL_WMASK;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Read values, with state bits merged in and masked fields forced low.
  wire logic [15:0] ctrl1_view = (ctrl1_r & ~(16'h0001 << SIMULTANEOUS_SAMPLE_BIT)) |
                                 (16'(simultaneous_sample) << SIMULTANEOUS_SAMPLE_BIT) |
                                 (16'(sample_active) << SAMPLE_ACTIVE_BIT) | 16'(done_r);
  wire logic [15:0] ctrl2_view = (ctrl2_r & ~(16'h0003 << CHPS_LSB)) |
                                 (16'(channel_count) << CHPS_LSB) |
                                 (16'(buffer_half_status) << BUFFER_HALF_STATUS_BIT);
  wire logic [15:0] reg_sel = (addr == REG_CTRL1) ? ctrl1_view :
                              (addr == REG_CTRL2) ? ctrl2_view :
                              (addr == REG_CTRL3) ? ctrl3_r :
                              (addr == REG_CHSEL) ? chsel_r : 16'h0000;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_q_r <= 16'h0000;
      rd_mem_r <= 1'b0;
    end else begin
      reg_q_r <= rd_en ? reg_sel : 16'h0000;
      rd_mem_r <= rd_en & addr[BUF_SEL_BIT];
    end
  end
  assign rdata = rd_mem_r ? mem_q : reg_q_r;

  // ****************************************
  // Converter-facing outputs
  // ****************************************
  wire logic use_b = alternate_sample_mode & alt_b_r;
  assign analog_ctrl.enable = conv_on;
  assign analog_ctrl.sampling = sample_active;
  assign analog_ctrl.start = (state_r == S_START);
  assign analog_ctrl.chan = ch_r;
  assign analog_ctrl.simult = simultaneous_sample & (channel_count != 2'h0);
  assign analog_ctrl.use_b = use_b;
  assign analog_ctrl.scan = scan_enable & ~use_b;
  assign analog_ctrl.ref_pos_ext = ~reference_config[2] & reference_config[0];
  assign analog_ctrl.ref_neg_ext = ~reference_config[2] & reference_config[1];
  assign analog_ctrl.neg_pins = use_b ? neg_to_pins(group_neg_input_b, resolution_select) :
                                neg_to_pins(group_neg_input_a, resolution_select);
  assign analog_ctrl.rc_clk = rc_clock_select;
  assign converter_interrupt_flag = irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_off_holds: assert property (!conv_on |=> state_r == S_OFF)
    else $error("converter ran while disabled");
  chk_idle_freeze: assert property (halted && conv_on |=> $stable(state_r))
    else $error("sequence moved while halted in idle");
  chk_done_set: assert property (seq_done |=> done_r)
    else $error("done not set after sequence");
  chk_done_clear: assert property (start_conv |=> !done_r)
    else $error("done not cleared at conversion start");
  chk_sw_end: assert property (sample_active && trigger_source == TRIG_SW && sw_sample_active_clr
    && conv_on && !halted |=> analog_ctrl.start)
    else $error("software clear did not start conversion");
  chk_auto_restart: assert property (seq_done && auto_sample_start && conv_on
    && !halted |=> sample_active)
    else $error("sampling not restarted");
  chk_irq_pace: assert property (converter_interrupt_flag |=> seq_cnt_r == 4'h0
    && wptr_r[2:0] == 3'h0)
    else $error("interrupt at wrong sequence");
  chk_half_swap: assert property (irq && split_buffer_mode |=> half_r != $past(half_r))
    else $error("buffer half did not swap");
  chk_int_format: assert property (buf_we && output_format == FMT_INT
    |-> fmt_data[15:12] == 4'h0)
    else $error("integer format upper bits not zero");
  cov_sequence: cover property (seq_done);
  cov_interrupt: cover property (irq && split_buffer_mode);
  cov_auto_end: cover property (sample_active && trigger_source == TRIG_AUTO ##1 analog_ctrl.start);
endmodule

/* File: tb/conv_core_model.sv */
// Behavioural converter core that answers each start pulse with one result.
// Assumes start pulses and results share clk; the bench sets the latency.
`timescale 1ns/1ps
module conv_core_model import adc_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire analog_ctrl_t analog_ctrl,
  input wire logic [7:0] latency,
  input wire logic [11:0] code,
  output conv_result_t conv_result
);
  // ****************************************
  // Conversion timer
  // ****************************************
  int left_r;
  // One result per start; the data lines change every cycle outside done.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      left_r <= 0;
      conv_result <= '0;
    end else begin
      conv_result.done <= (left_r == 1);
      conv_result.data <= (left_r == 1) ? code : ~conv_result.data;
      if (analog_ctrl.start) begin
        left_r <= int'(latency);
      end else if (left_r > 0) begin
        left_r <= left_r - 1;
      end
    end
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the converter sequencer through its register port.
// Assumes the converter core model answers start pulses after a set latency.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb import adc_pkg::*;;
  logic clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, t3 = 1'b0;
  logic p1 = 1'b0, p2 = 1'b0, ext = 1'b0, idle = 1'b0, irq;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [7:0] lat = 8'h0a;
  logic [15:0] fmt_exp [8] = '{16'h025c, 16'h005c, 16'h9700, 16'h1700,
    16'h0a5c, 16'h025c, 16'ha5c0, 16'h25c0};
  conv_result_t conv_result;
  analog_ctrl_t analog_ctrl;
  // Routing and reference outputs gathered for one compare.
  wire logic [6:0] fields = {analog_ctrl.ref_pos_ext, analog_ctrl.ref_neg_ext,
    analog_ctrl.scan, analog_ctrl.neg_pins, analog_ctrl.use_b, analog_ctrl.simult,
    analog_ctrl.rc_clk};
  int fails = 0, comparisons = 0, cyc = 0, dones = 0, irqs = 0, starts = 0, s0, d0;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h5};
  adc_sequencer_control i_adc_sequencer_control (.clk(clk), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .idle_mode(idle), .trig_timer3(t3), .trig_pwm1(p1), .trig_pwm2(p2),
    .external_trigger_pin(ext), .rc_osc_pin(1'b0), .conv_result(conv_result),
    .analog_ctrl(analog_ctrl), .converter_interrupt_flag(irq));
  conv_core_model i_conv_core_model (.clk(clk), .reset_n(reset_n),
    .analog_ctrl(analog_ctrl), .latency(lat), .code(12'ha5c), .conv_result(conv_result));
  // ****************************************
  // Clock, monitors and hang guard
  // ****************************************
  always #20 clk = ~clk;
  // Counts results, interrupt pulses and starts, and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (conv_result.done === 1'b1) dones++;
    if (irq === 1'b1) irqs++;
    if (analog_ctrl.start === 1'b1) starts++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // One-cycle read strobe; the data is compared in the following cycle.
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK(n, e, rdata)
  endtask
  // Waits a bounded time for a monitor count to reach a target.
  task automatic wait_for(input int which, input int target);
    for (int k = 0; k < 3000; k++) begin
      if ((which == 0 ? dones : which == 1 ? irqs : starts) >= target) break;
      @(posedge clk);
    end
  endtask
  // Pulses one trigger source; the pin is held high across its synchroniser.
  task automatic pulse(input logic [2:0] c);
    @(posedge clk);
    t3 <= (c == TRIG_TMR3);
    p1 <= (c == TRIG_PWM1);
    p2 <= (c == TRIG_PWM2);
    ext <= (c == TRIG_EXT);
    @(posedge clk);
    {t3, p1, p2} <= 3'h0;
    repeat (4) @(posedge clk);
    ext <= 1'b0;
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 6; a++) rd(5'(a), 16'h0000, "reset value");
    wr(5'h05, 16'hffff);
    rd(5'h05, 16'h0000, "unmapped");
    wr(REG_CTRL1, 16'h5b10);
    rd(REG_CTRL1, 16'h0300, "ctrl1 bits");
    wr(REG_CTRL2, 16'hffff);
    rd(REG_CTRL2, 16'he73f, "ctrl2 bits");
    wr(REG_CTRL3, 16'hffff);
    rd(REG_CTRL3, 16'h9fff, "ctrl3 bits");
    wr(REG_CHSEL, 16'hffff);
    rd(REG_CHSEL, 16'h0707, "chsel bits");
    {wr_en, rd_en} <= 2'h0;
    wr(REG_CTRL2, 16'h0000);
    wr(REG_CTRL3, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      logic [15:0] base;
      base = 16'h8000 | (16'(i / 4) << RES_BIT) | (16'(i % 4) << FORM_LSB);
      if (i % 4 == 0) begin
        wr(REG_CTRL1, 16'h0000);
        wr(REG_CTRL1, base & 16'h7fff);
        wr(REG_CTRL1, base);
      end
      if (i == 4) begin
        wr(REG_CTRL2, 16'h0300);
        rd(REG_CTRL2, 16'h0000, "count in 12-bit");
        wr(REG_CTRL2, 16'h0000);
      end
      d0 = dones;
      s0 = irqs;
      wr(REG_CTRL1, base | 16'h0002);
      repeat (3) @(posedge clk);
      wr(REG_CTRL1, base);
      rd(REG_CTRL1, base, "done at start");
      wait_for(0, d0 + 1);
      @(negedge clk);
      rd(REG_CTRL1, base | 16'h0001, "done set");
      rd(5'h10, fmt_exp[i], "result word");
      `CHK("irq per sequence", s0 + 1, irqs)
    end
    $display("test formats done");
    lat <= 8'h02;
    wr(REG_CTRL1, 16'h0000);
    wr(REG_CTRL2, 16'h000a);
    wr(REG_CTRL3, 16'h0100);
    d0 = dones;
    s0 = irqs;
    wr(REG_CTRL1, 16'h80e4);
    wait_for(1, s0 + 1);
    rd(REG_CTRL2, 16'h008a, "second half");
    wait_for(1, s0 + 2);
    `CHK("sequences per irq", d0 + 6, dones)
    rd(REG_CTRL2, 16'h000a, "first half");
    wr(REG_CTRL1, 16'h0000);
    wr(REG_CTRL2, 16'h0000);
    wr(REG_CTRL3, 16'h0000);
    $display("test pacing done");
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL1, 16'h8004 | (16'(codes[i]) << SSRC_LSB));
      repeat (4) @(posedge clk);
      s0 = starts;
      pulse(codes[i] == TRIG_TMR3 ? TRIG_PWM1 : TRIG_TMR3);
      repeat (8) @(posedge clk);
      `CHK("wrong trigger", s0, starts)
      pulse(codes[i]);
      wait_for(2, s0 + 1);
      `CHK("right trigger", s0 + 1, starts)
      wr(REG_CTRL1, 16'h0000);
    end
    wr(REG_CTRL2, 16'h6501);
    wr(REG_CTRL3, 16'h8000);
    wr(REG_CHSEL, 16'h0004);
    wr(REG_CTRL1, 16'ha008);
    wr(REG_CTRL1, 16'ha00a);
    @(negedge clk);
    `CHK("sample a fields", 7'h7b, fields)
    @(posedge clk);
    s0 = starts;
    idle <= 1'b1;
    wr(REG_CTRL1, 16'ha008);
    repeat (4) @(posedge clk);
    `CHK("halted in idle", s0, starts)
    idle <= 1'b0;
    wr(REG_CTRL1, 16'ha008);
    wait_for(2, s0 + 2);
    `CHK("starts per sequence", s0 + 2, starts)
    @(negedge clk);
    `CHK("sample b fields", 7'h67, fields)
    wr(REG_CTRL1, 16'h0000);
    s0 = starts;
    wr(REG_CTRL1, 16'h0002);
    repeat (10) @(posedge clk);
    `CHK("off converter", s0, starts)
    `CHK("enable low", 1'b0, analog_ctrl.enable)
    $display("test triggers done");
    test_done();
  end
endmodule
